// ==== mpi_pkg.sv ====
/*
 * Package for the MPPT controller serial register port.
 * Holds register indices, field positions, reset values and timing.
 * Assumes a 25 MHz system clock and a standard-rate serial bus.
 */
package mpi_pkg;
    // ==========================================================
    // Register map
    // ==========================================================
    localparam int REG_W = 56;
    localparam int REG_BYTES = 7;
    localparam logic [7:0] CMD_BASE = 8'hE0;
    localparam logic [2:0] IDX_ADC_SETTING = 3'h0;
    localparam logic [2:0] IDX_MEASUREMENT = 3'h1;
    localparam logic [2:0] IDX_CONTROL = 3'h3;
    localparam logic [2:0] IDX_TRIM = 3'h4;
    localparam logic [2:0] IDX_THRESH = 3'h5;

    // ==========================================================
    // Fields and reset values
    // ==========================================================
    localparam int DUTY_LSB = 5;
    localparam int DUTY_W = 9;
    localparam int OPEN_LOOP_BIT = 0;
    localparam int TRIM_IIN_LSB = 0;
    localparam int TRIM_VIN_LSB = 8;
    localparam int TRIM_IOUT_LSB = 16;
    localparam int TRIM_VOUT_LSB = 24;
    localparam int TH_IOUT_LO_LSB = 0;
    localparam int TH_IOUT_HI_LSB = 10;
    localparam int TH_IIN_LO_LSB = 20;
    localparam int TH_IIN_HI_LSB = 30;
    localparam logic [55:0] CONTROL_RESET = 56'h0000_08FF_FFF6_DFE0;
    localparam logic [55:0] TRIM_RESET = 56'h0;
    localparam logic [9:0] TH_HIGH_RESET = 10'h028;
    localparam logic [9:0] TH_LOW_RESET = 10'h018;
    localparam logic [55:0] THRESH_RESET =
        {16'h0000, TH_HIGH_RESET, TH_LOW_RESET, TH_HIGH_RESET, TH_LOW_RESET};

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ = 25_000_000;
    localparam int BUS_HZ = 100_000;
    localparam int BUS_CYCLES = CLK_HZ / BUS_HZ;

    typedef enum logic [2:0] {
        MPI_IDLE = 3'b000,
        MPI_ADDR = 3'b001,
        MPI_ACK = 3'b011,
        MPI_RX = 3'b010,
        MPI_TX = 3'b110,
        MPI_TXACK = 3'b111
    } mpi_state_t;

    function automatic logic [9:0] mpi_trim(input logic [9:0] raw, input logic [7:0] offs);
        logic [10:0] s;
        s = {1'b0, raw} + {3'h0, offs};
        mpi_trim = s[10] ? 10'h3FF : s[9:0];
    endfunction
endpackage

// ==== mpi_reg_bank.sv ====
/*
 * Writable register bank: control, trim and threshold words.
 * Assumes byte writes arrive from the serial engine on the system clock.
 */
`timescale 1ns/1ps
module mpi_reg_bank
    import mpi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [2:0] wrIdx,
    input wire logic [2:0] wrByte,
    input wire logic [7:0] wrData,
    input wire logic [2:0] rdIdx,
    input wire logic [REG_W-1:0] roAdc,
    input wire logic [REG_W-1:0] roMeas,
    output logic [REG_W-1:0] rdData,
    output logic [REG_W-1:0] controlWord,
    output logic [REG_W-1:0] trimWord,
    output logic [REG_W-1:0] threshWord
);
    logic [REG_W-1:0] ctl_reg, ctl_next, trm_reg, trm_next, thr_reg, thr_next;
    logic [REG_W-1:0] rd_reg, rd_next;

    always_comb begin
        ctl_next = ctl_reg;
        trm_next = trm_reg;
        thr_next = thr_reg;
        if (wrEn) begin
            unique case (wrIdx)
                IDX_CONTROL: ctl_next[wrByte*8 +: 8] = wrData;
                IDX_TRIM: trm_next[wrByte*8 +: 8] = wrData;
                IDX_THRESH: thr_next[wrByte*8 +: 8] = wrData;
                default: ;
            endcase
        end
        unique case (rdIdx)
            IDX_ADC_SETTING: rd_next = roAdc;
            IDX_MEASUREMENT: rd_next = roMeas;
            IDX_CONTROL: rd_next = ctl_reg;
            IDX_TRIM: rd_next = trm_reg;
            IDX_THRESH: rd_next = thr_reg;
            default: rd_next = '0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctl_reg <= CONTROL_RESET;
            trm_reg <= TRIM_RESET;
            thr_reg <= THRESH_RESET;
            rd_reg <= '0;
        end else begin
            ctl_reg <= ctl_next;
            trm_reg <= trm_next;
            thr_reg <= thr_next;
            rd_reg <= rd_next;
        end
    end

    assign rdData = rd_reg;
    assign controlWord = ctl_reg;
    assign trimWord = trm_reg;
    assign threshWord = thr_reg;
endmodule

// ==== mpi_i2c_target.sv ====
/*
 * Serial target port of the MPPT controller: 7-byte register blocks,
 * command codes from 0xE0, strap-selected address, plus trim, threshold
 * and duty outputs. Assumes external pull-ups; SCL/SDA are asynchronous.
 */
`timescale 1ns/1ps
module mpi_i2c_target
    import mpi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addr_strap_msb,
    input wire logic addr_strap_mid,
    input wire logic addr_strap_lsb,
    input wire logic [9:0] input_current_sense,
    input wire logic [9:0] output_current_sense,
    input wire logic [9:0] inputVoltageSense,
    input wire logic [9:0] outputVoltageSense,
    input wire logic [REG_W-1:0] adcSettingWord,
    input wire logic mpptOk,
    output logic [9:0] inputCurrentTrimmed,
    output logic [9:0] outputCurrentTrimmed,
    output logic [9:0] inputVoltageTrimmed,
    output logic [9:0] outputVoltageTrimmed,
    output logic trackEnter,
    output logic trackExit,
    output logic openLoopEn,
    output logic [DUTY_W-1:0] open_loop_duty,
    output logic [REG_W-1:0] controlWord
);
    // ==========================================================
    // Synchronisers and strap capture
    // ==========================================================
    logic [1:0] sclS_reg, sdaS_reg, sclS_next, sdaS_next;
    logic sclD_reg, sdaD_reg;
    logic [2:0] strapS1_reg, strapS2_reg;
    logic [2:0] myAddr_reg, myAddr_next;
    logic [1:0] strapCnt_reg, strapCnt_next;

    always_comb begin
        sclS_next = {sclS_reg[0], sclIn};
        sdaS_next = {sdaS_reg[0], sdaIn};
        myAddr_next = myAddr_reg;
        strapCnt_next = (strapCnt_reg == 2'h3) ? strapCnt_reg : strapCnt_reg + 2'h1;
        if (strapCnt_reg == 2'h2) begin
            myAddr_next = strapS2_reg;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclS_reg <= 2'h3;
            sdaS_reg <= 2'h3;
            sclD_reg <= 1'b1;
            sdaD_reg <= 1'b1;
            strapS1_reg <= 3'h0;
            strapS2_reg <= 3'h0;
            myAddr_reg <= 3'h0;
            strapCnt_reg <= 2'h0;
        end else begin
            sclS_reg <= sclS_next;
            sdaS_reg <= sdaS_next;
            sclD_reg <= sclS_reg[1];
            sdaD_reg <= sdaS_reg[1];
            strapS1_reg <= {addr_strap_msb, addr_strap_mid, addr_strap_lsb};
            strapS2_reg <= strapS1_reg;
            myAddr_reg <= myAddr_next;
            strapCnt_reg <= strapCnt_next;
        end
    end

    logic scl, sda, sclRise, sclFall, startCond, stopCond;
    assign scl = sclS_reg[1];
    assign sda = sdaS_reg[1];
    assign sclRise = scl && !sclD_reg;
    assign sclFall = !scl && sclD_reg;
    assign startCond = scl && sclD_reg && !sda && sdaD_reg;
    assign stopCond = scl && sclD_reg && sda && !sdaD_reg;

    // ==========================================================
    // Protocol engine
    // ==========================================================
    mpi_state_t st_reg, st_next;
    logic [7:0] sh_reg, sh_next;
    logic [2:0] bit_reg, bit_next;
    logic [2:0] idx_reg, idx_next;
    logic idxOk_reg, idxOk_next;
    logic gotCmd_reg, gotCmd_next;
    logic [2:0] byte_reg, byte_next;
    logic rw_reg, rw_next, gotByte_reg, gotByte_next;
    logic drive_reg, drive_next;
    logic masterAck_reg, masterAck_next;
    logic wrEn;
    logic [REG_W-1:0] rdData, trimWord, threshWord;

    always_comb begin
        st_next = st_reg;
        sh_next = sh_reg;
        bit_next = bit_reg;
        idx_next = idx_reg;
        idxOk_next = idxOk_reg;
        gotCmd_next = gotCmd_reg;
        byte_next = byte_reg;
        rw_next = rw_reg;
        gotByte_next = gotByte_reg;
        drive_next = drive_reg;
        masterAck_next = masterAck_reg;
        wrEn = 1'b0;
        if (startCond) begin
            st_next = MPI_ADDR;
            bit_next = 3'h0;
            gotByte_next = 1'b0;
            drive_next = 1'b0;
        end else if (stopCond) begin
            st_next = MPI_IDLE;
            gotCmd_next = 1'b0;
            drive_next = 1'b0;
        end else begin
            unique case (st_reg)
                MPI_IDLE: ;
                MPI_ADDR, MPI_RX: begin
                    if (sclRise) begin
                        sh_next = {sh_reg[6:0], sda};
                        gotByte_next = bit_reg == 3'h7;
                        bit_next = bit_reg + 3'h1;
                    end
                    if (sclFall && gotByte_reg) begin
                        // Eight bits in: decide whether to acknowledge
                        if (st_reg == MPI_ADDR) begin
                            if (sh_reg[7:1] == {4'h0, myAddr_reg}) begin
                                rw_next = sh_reg[0];
                                byte_next = 3'h0;
                                drive_next = 1'b1;
                                st_next = MPI_ACK;
                            end else begin
                                st_next = MPI_IDLE;
                            end
                        end else if (!gotCmd_reg) begin
                            idx_next = sh_reg[2:0] ;
                            idxOk_next = sh_reg[7:3] == CMD_BASE[7:3];
                            gotCmd_next = 1'b1;
                            drive_next = 1'b1;
                            st_next = MPI_ACK;
                        end else begin
                            wrEn = idxOk_reg && byte_reg < REG_BYTES[2:0];
                            byte_next = (byte_reg == 3'h7) ? byte_reg : byte_reg + 3'h1;
                            drive_next = 1'b1;
                            st_next = MPI_ACK;
                        end
                    end
                end
                MPI_ACK: begin
                    if (sclFall) begin
                        bit_next = 3'h0;
                        sh_next = 8'h0;
                        if (rw_reg) begin
                            sh_next = rdData[byte_reg*8 +: 8];
                            drive_next = !rdData[byte_reg*8 + 7];
                            st_next = MPI_TX;
                        end else begin
                            drive_next = 1'b0;
                            st_next = MPI_RX;
                        end
                    end
                end
                MPI_TX: begin
                    if (sclFall) begin
                        bit_next = bit_reg + 3'h1;
                        sh_next = {sh_reg[6:0], 1'b0};
                        drive_next = (bit_reg == 3'h7) ? 1'b0 : !sh_reg[6];
                        if (bit_reg == 3'h7) begin
                            st_next = MPI_TXACK;
                        end
                    end
                end
                MPI_TXACK: begin
                    if (sclRise) begin
                        masterAck_next = !sda;
                    end
                    if (sclFall) begin
                        if (masterAck_reg && byte_reg < 3'h6) begin
                            byte_next = byte_reg + 3'h1;
                            bit_next = 3'h0;
                            sh_next = rdData[{byte_reg + 3'h1, 3'h0} +: 8];
                            drive_next = !rdData[{byte_reg + 3'h1, 3'h7}];
                            st_next = MPI_TX;
                        end else begin
                            st_next = MPI_IDLE;
                        end
                    end
                end
                default: st_next = MPI_IDLE;
            endcase
        end
        if (startCond && st_reg == MPI_IDLE) begin
            gotCmd_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= MPI_IDLE;
            sh_reg <= 8'h0;
            bit_reg <= 3'h0;
            idx_reg <= 3'h0;
            idxOk_reg <= 1'b0;
            gotCmd_reg <= 1'b0;
            byte_reg <= 3'h0;
            rw_reg <= 1'b0;
            gotByte_reg <= 1'b0;
            drive_reg <= 1'b0;
            masterAck_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            sh_reg <= sh_next;
            bit_reg <= bit_next;
            idx_reg <= idx_next;
            idxOk_reg <= idxOk_next;
            gotCmd_reg <= gotCmd_next;
            byte_reg <= byte_next;
            rw_reg <= rw_next;
            gotByte_reg <= gotByte_next;
            drive_reg <= drive_next;
            masterAck_reg <= masterAck_next;
        end
    end

    // Open drain: only ever pull low
    assign sdaOut = 1'b0;
    assign sdaOe = drive_reg;

    mpi_reg_bank u_bank (
        .clk_sys(clk_sys),
        .rst(rst),
        .wrEn(wrEn),
        .wrIdx(idx_reg),
        .wrByte(byte_reg),
        .wrData(sh_reg),
        .rdIdx(idx_reg),
        .roAdc(adcSettingWord),
        .roMeas({15'h0, mpptOk, outputVoltageTrimmed, outputCurrentTrimmed,
                 inputVoltageTrimmed, inputCurrentTrimmed}),
        .rdData(rdData),
        .controlWord(controlWord),
        .trimWord(trimWord),
        .threshWord(threshWord)
    );

    // ==========================================================
    // Trims, thresholds, duty
    // ==========================================================
    logic [9:0] iinT_next, ioutT_next, vinT_next, voutT_next;
    logic enter_next, exit_next;

    always_comb begin
        iinT_next = mpi_trim(input_current_sense, trimWord[TRIM_IIN_LSB +: 8]);
        vinT_next = mpi_trim(inputVoltageSense, trimWord[TRIM_VIN_LSB +: 8]);
        ioutT_next = mpi_trim(output_current_sense, trimWord[TRIM_IOUT_LSB +: 8]);
        voutT_next = mpi_trim(outputVoltageSense, trimWord[TRIM_VOUT_LSB +: 8]);
        enter_next = input_current_sense > threshWord[TH_IIN_HI_LSB +: 10]
            && output_current_sense > threshWord[TH_IOUT_HI_LSB +: 10];
        exit_next = input_current_sense < threshWord[TH_IIN_LO_LSB +: 10]
            || output_current_sense < threshWord[TH_IOUT_LO_LSB +: 10];
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            inputCurrentTrimmed <= 10'h000;
            outputCurrentTrimmed <= 10'h000;
            inputVoltageTrimmed <= 10'h000;
            outputVoltageTrimmed <= 10'h000;
            trackEnter <= 1'b0;
            trackExit <= 1'b0;
            openLoopEn <= 1'b0;
            open_loop_duty <= 9'h0FF;
        end else begin
            inputCurrentTrimmed <= iinT_next;
            outputCurrentTrimmed <= ioutT_next;
            inputVoltageTrimmed <= vinT_next;
            outputVoltageTrimmed <= voutT_next;
            trackEnter <= enter_next;
            trackExit <= exit_next;
            openLoopEn <= controlWord[OPEN_LOOP_BIT];
            open_loop_duty <= controlWord[DUTY_LSB +: DUTY_W];
        end
    end
endmodule

// ==== mpi_i2c_target_sva.sv ====
/* Checker bound to the serial register port.
   Assumes one clock domain and the package constants. */
`timescale 1ns/1ps
module mpi_i2c_target_sva
    import mpi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [9:0] input_current_sense,
    input wire logic [9:0] output_current_sense,
    input wire logic [9:0] inputCurrentTrimmed,
    input wire logic [9:0] outputCurrentTrimmed,
    input wire logic openLoopEn,
    input wire logic [DUTY_W-1:0] open_loop_duty,
    input wire logic [REG_W-1:0] controlWord
);
    // ==========================================================
    // Helpers and properties
    default clocking cbk @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic [REG_W-1:0] cwPrev;
    logic [6:0] byteChg;
    always_ff @(posedge clk_sys) begin
        cwPrev <= controlWord;
    end
    always_comb begin
        for (int k = 0; k < REG_BYTES; k++) begin
            byteChg[k] = controlWord[8*k +: 8] != cwPrev[8*k +: 8];
        end
    end
    function automatic logic inRange(input logic [9:0] t, input logic [9:0] r);
        return {1'h0, t} >= {1'h0, r} && {1'h0, t} <= {1'h0, r} + 11'h0FF;
    endfunction
    property p_duty_follows;
        $stable(controlWord) [*2] |-> open_loop_duty == controlWord[DUTY_LSB +: DUTY_W];
    endproperty
    a_duty_follows: assert property (p_duty_follows) else $error("duty mismatch");
    property p_open_loop;
        $stable(controlWord) [*2] |-> openLoopEn == controlWord[OPEN_LOOP_BIT];
    endproperty
    a_open_loop: assert property (p_open_loop) else $error("open loop mismatch");
    property p_trim_in;
        1'h1 |=> inRange(inputCurrentTrimmed, $past(input_current_sense));
    endproperty
    a_trim_in: assert property (p_trim_in) else $error("input trim out of range");
    property p_trim_out;
        1'h1 |=> inRange(outputCurrentTrimmed, $past(output_current_sense));
    endproperty
    a_trim_out: assert property (p_trim_out) else $error("output trim out of range");
    property p_open_drain;
        sdaOut == 1'h0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data driven high");
    property p_sda_low_clock;
        $changed(sdaOe) |-> !sclIn;
    endproperty
    a_sda_low_clock: assert property (p_sda_low_clock) else $error("data moved");
    property p_bit_stands;
        $rose(sdaOe) |-> sdaOe [*8];
    endproperty
    a_bit_stands: assert property (p_bit_stands) else $error("short low bit");
    property p_byte_write;
        $onehot0(byteChg);
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("bytes changed together");
endmodule
bind mpi_i2c_target mpi_i2c_target_sva chk (.clk_sys(clk_sys), .rst(rst), .sclIn(sclIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .input_current_sense(input_current_sense),
    .output_current_sense(output_current_sense), .inputCurrentTrimmed(inputCurrentTrimmed),
    .outputCurrentTrimmed(outputCurrentTrimmed), .openLoopEn(openLoopEn),
    .open_loop_duty(open_loop_duty), .controlWord(controlWord));

// ==== mpi_bus_master.sv ====
/* Serial bus master model, bit level, 100 kHz.
   Assumes the bench resolves the open-drain data line. */
`timescale 1ns/1ps
module mpi_bus_master
    import mpi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaPull
);
    // ==========================================================
    // Bit and frame tasks
    localparam int HALF = BUS_CYCLES / 2;
    localparam int QTR = HALF / 2;
    initial begin
        scl = 1'h1;
        sdaPull = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic xbit(input logic b, output logic r);
        sdaPull <= ~b;
        tick(QTR);
        scl <= 1'h1;
        tick(QTR);
        @(negedge clk_sys);
        r = sdaLine;
        tick(HALF - QTR);
        scl <= 1'h0;
        tick(HALF - QTR);
    endtask
    task automatic start();
        @(posedge clk_sys);
        sdaPull <= 1'h1;
        tick(HALF);
        scl <= 1'h0;
        tick(QTR);
    endtask
    task automatic restart();
        sdaPull <= 1'h0;
        tick(QTR);
        scl <= 1'h1;
        tick(QTR);
        sdaPull <= 1'h1;
        tick(QTR);
        scl <= 1'h0;
        tick(QTR);
    endtask
    task automatic stop();
        sdaPull <= 1'h1;
        tick(QTR);
        scl <= 1'h1;
        tick(QTR);
        sdaPull <= 1'h0;
        tick(HALF);
    endtask
    task automatic tx_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(b[i], r);
        end
        xbit(1'h1, r);
        ack = (r === 1'h0);
    endtask
    task automatic rx_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'h1, d[i]);
        end
        xbit(last, r);
    endtask
    task automatic probe(input logic [2:0] a, output logic ok);
        start();
        tx_byte({4'h0, a, 1'h0}, ok);
        stop();
    endtask
    // Start, address for write, then command byte
    task automatic head(input logic [2:0] a, input logic [2:0] idx, output logic ok);
        logic k;
        start();
        tx_byte({4'h0, a, 1'h0}, ok);
        tx_byte(CMD_BASE + {5'h0, idx}, k);
        ok = ok & k;
    endtask
    task automatic write_reg(input logic [2:0] a, input logic [2:0] idx,
        input logic [REG_W-1:0] v, output logic ok);
        logic k;
        head(a, idx, ok);
        for (int j = 0; j < REG_BYTES; j++) begin
            tx_byte(v[8*j +: 8], k);
            ok = ok & k;
        end
        stop();
    endtask
    task automatic read_reg(input logic [2:0] a, input logic [2:0] idx,
        output logic [REG_W-1:0] v, output logic ok);
        logic k;
        head(a, idx, ok);
        restart();
        tx_byte({4'h0, a, 1'h1}, k);
        ok = ok & k;
        for (int j = 0; j < REG_BYTES; j++) begin
            rx_byte(j == REG_BYTES - 1, v[8*j +: 8]);
        end
        stop();
    endtask
endmodule

// ==== tb.sv ====
/* Self-checking bench for the serial register port.
   Assumes the master model and the bound checker. */
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            failCount++; \
            $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
        end \
    end
module tb;
    import mpi_pkg::*;
    localparam int LIMIT = 99000;
    logic clk_sys, rst, sclIn, sdaPull, sdaLine, sdaOut, sdaOe, mpptOk;
    logic [2:0] strap;
    logic [9:0] iinS, ioutS, vinS, voutS, iinT, ioutT, vinT, voutT;
    logic trackEnter, trackExit, openLoopEn;
    logic [DUTY_W-1:0] duty;
    logic [REG_W-1:0] adcWord, controlWord;
    int failCount = 0;
    int comparisons = 0;
    int cycles = 0;
    assign sdaLine = ~((sdaOe & ~sdaOut) | sdaPull);
    mpi_i2c_target dut (.clk_sys(clk_sys), .rst(rst), .sclIn(sclIn), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_strap_msb(strap[2]), .addr_strap_mid(strap[1]),
        .addr_strap_lsb(strap[0]), .input_current_sense(iinS), .output_current_sense(ioutS),
        .inputVoltageSense(vinS), .outputVoltageSense(voutS), .adcSettingWord(adcWord),
        .mpptOk(mpptOk), .inputCurrentTrimmed(iinT), .outputCurrentTrimmed(ioutT),
        .inputVoltageTrimmed(vinT), .outputVoltageTrimmed(voutT), .trackEnter(trackEnter),
        .trackExit(trackExit), .openLoopEn(openLoopEn), .open_loop_duty(duty),
        .controlWord(controlWord));
    mpi_bus_master master (.clk_sys(clk_sys), .sdaLine(sdaLine), .scl(sclIn),
        .sdaPull(sdaPull));
    // ==========================================================
    // Clock, timeout and helpers
    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            failCount++;
            printVerdict();
        end
    end
    task automatic printVerdict();
        if (failCount == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    function automatic logic [REG_W-1:0] ctrlReset();
        return {9'h0, 1'h0, 1'h0, 2'h1, 1'h0, 2'h0, 10'h3FF, 10'h3FF, 3'h3, 3'h3, 9'h0FF, 5'h0};
    endfunction
    // ==========================================================
    // Scenarios
    task automatic t_reset_vals();
        settle(1);
        `CHK(controlWord, ctrlReset())
        `CHK(duty, 9'h0FF)
        `CHK(iinT, iinS)
        `CHK(trackExit, 1'h1)
    endtask
    task automatic t_track();
        logic [21:0] rows [6];
        rows = '{{10'h029, 10'h029, 2'h2}, {10'h028, 10'h029, 2'h0}, {10'h029, 10'h028, 2'h0},
            {10'h017, 10'h01E, 2'h1}, {10'h01E, 10'h017, 2'h1}, {10'h018, 10'h018, 2'h0}};
        foreach (rows[i]) begin
            @(posedge clk_sys);
            iinS <= rows[i][21:12];
            ioutS <= rows[i][11:2];
            settle(3);
            `CHK(trackEnter, rows[i][1])
            `CHK(trackExit, rows[i][0])
        end
    endtask
    task automatic t_straps();
        logic ok;
        @(posedge clk_sys);
        strap <= 3'h6;
        master.probe(3'h6, ok);
        `CHK(ok, 1'h0)
        master.probe(3'h5, ok);
        `CHK(ok, 1'h1)
    endtask
    task automatic t_control();
        logic [REG_W-1:0] v;
        logic ok;
        v = ctrlReset();
        v[13:5] = 9'h155;
        v[0] = 1'h1;
        master.write_reg(3'h5, IDX_CONTROL, v, ok);
        settle(3);
        `CHK({ok, controlWord}, {1'h1, v})
        `CHK(duty, 9'h155)
        `CHK(openLoopEn, 1'h1)
    endtask
    task automatic t_trim();
        logic [REG_W-1:0] v, rd;
        logic ok;
        v = 56'hA5_C3E1_0005_FF10;
        master.write_reg(3'h5, IDX_TRIM, v, ok);
        iinS <= 10'h064;
        vinS <= 10'h300;
        ioutS <= 10'h3FC;
        voutS <= 10'h007;
        settle(3);
        `CHK({iinT, vinT}, {10'h074, 10'h3FF})
        `CHK({ioutT, voutT}, {10'h3FF, 10'h007})
        master.read_reg(3'h5, IDX_TRIM, rd, ok);
        `CHK({ok, rd}, {1'h1, v})
    endtask
    task automatic t_adc();
        logic [REG_W-1:0] rd;
        logic ok;
        master.read_reg(3'h5, IDX_ADC_SETTING, rd, ok);
        `CHK({ok, rd}, {1'h1, adcWord})
    endtask
    task automatic t_rearm();
        logic ok;
        @(posedge clk_sys);
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        settle(1);
        `CHK(duty, 9'h0FF)
        repeat (10) @(posedge clk_sys);
        master.probe(3'h6, ok);
        `CHK(ok, 1'h1)
    endtask
    initial begin
        rst = 1'h1;
        strap = 3'h5;
        {iinS, ioutS, vinS, voutS} = 40'h0;
        adcWord = 56'h3C_5A96_0F1E_2D4B;
        mpptOk = 1'h1;
        repeat (16) @(posedge clk_sys);
        rst <= 1'h0;
        repeat (10) @(posedge clk_sys);
        t_reset_vals();
        t_track();
        t_straps();
        t_control();
        t_trim();
        t_adc();
        t_rearm();
        printVerdict();
    end
endmodule
